// ### pfc_cfg.svh
// register offsets, field positions, reset values and timing counts of the flow-control bank
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_ADDR_W 9
`define PFC_DATA_W 32
`define PFC_P2_OFFSET 9'h1a4
`define PFC_P0_OFFSET 9'h1a8

`define PFC_FIELD_W 7
`define PFC_RSVD_W 25
`define PFC_BIT_BP 6
`define PFC_BIT_DUP 5
`define PFC_BIT_CUR_RX 4
`define PFC_BIT_CUR_TX 3
`define PFC_BIT_RX 2
`define PFC_BIT_TX 1
`define PFC_BIT_MAN 0

`define PFC_FIELD_RST 1'b0
`define PFC_MAC_MANUAL_RST 1'b1
`define PFC_STRAP_W 7
`define PFC_STRAP_SETTLE 2'h2
`define PFC_CNT_RST 2'h0
`define PFC_CNT_ONE 2'h1

`endif

// ### pfc_pkg.sv
// types shared by the flow-control register bank
`include "pfc_cfg.svh"

package pfc_pkg;
    typedef logic [`PFC_FIELD_W-1:0] pfc_field_t;

    // one port's strap set, as pins or as rewritten by the eeprom loader
    typedef struct packed {
        logic bp;
        logic pause;
        logic manual;
    } pfc_strap_s;

    // link state reported by the port's phy or negotiation engine
    typedef struct packed {
        logic an_enable;
        logic half_duplex;
        logic an_rx_pause;
        logic an_tx_pause;
    } pfc_link_s;
endpackage : pfc_pkg

// ### pfc_port_if.sv
// carrier between the bank top and one port slice
interface pfc_port_if;
    logic wr;
    pfc_pkg::pfc_field_t wdata;
    logic ld;
    pfc_pkg::pfc_strap_s ld_val;
    logic mac_mode;
    pfc_pkg::pfc_link_s link;
    pfc_pkg::pfc_field_t rdata;
    logic bp_en;
    logic rx_en;
    logic tx_en;

    modport ctl(
        output wr, wdata, ld, ld_val, mac_mode, link,
        input rdata, bp_en, rx_en, tx_en
    );
    modport port(
        input wr, wdata, ld, ld_val, mac_mode, link,
        output rdata, bp_en, rx_en, tx_en
    );
endinterface : pfc_port_if

// ### pfc_port.sv
// one port's flow-control fields and current-state tracking
`include "pfc_cfg.svh"

module pfc_port #(
    parameter bit HAS_MAC_MODE = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    pfc_port_if.port p
);
    logic bp_q;
    logic rx_q;
    logic tx_q;
    logic man_q;
    logic cur_dup_q;
    logic cur_rx_q;
    logic cur_tx_q;
    logic man_force;
    logic man_eff;
    logic manual_path;

    // mac-mode forcing only exists on the port that has that mode
    assign man_force = HAS_MAC_MODE & p.mac_mode;
    assign man_eff = man_force | man_q;
    assign manual_path = man_eff | ~p.link.an_enable;

    // configuration fields; a loader update wins over a same-cycle write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bp_q <= `PFC_FIELD_RST;
            rx_q <= `PFC_FIELD_RST;
            tx_q <= `PFC_FIELD_RST;
            man_q <= `PFC_FIELD_RST;
        end else if (p.ld) begin
            bp_q <= p.ld_val.bp;
            rx_q <= p.ld_val.pause;
            tx_q <= p.ld_val.pause;
            if (!man_force) begin
                man_q <= p.ld_val.manual;
            end
        end else if (p.wr) begin
            bp_q <= p.wdata[`PFC_BIT_BP];
            rx_q <= p.wdata[`PFC_BIT_RX];
            tx_q <= p.wdata[`PFC_BIT_TX];
            if (!man_force) begin
                man_q <= p.wdata[`PFC_BIT_MAN];
            end
        end
    end

    // current state: pause only matters in full duplex, so half duplex reads both off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_dup_q <= `PFC_FIELD_RST;
            cur_rx_q <= `PFC_FIELD_RST;
            cur_tx_q <= `PFC_FIELD_RST;
        end else begin
            cur_dup_q <= p.link.half_duplex;
            cur_rx_q <= ~p.link.half_duplex & (manual_path ? rx_q : p.link.an_rx_pause);
            cur_tx_q <= ~p.link.half_duplex & (manual_path ? tx_q : p.link.an_tx_pause);
        end
    end

    assign p.rdata = {bp_q, cur_dup_q, cur_rx_q, cur_tx_q, rx_q, tx_q, man_eff};
    assign p.bp_en = bp_q;
    assign p.rx_en = cur_rx_q;
    assign p.tx_en = cur_tx_q;

    // a loader pulse, either the strap capture or an eeprom rewrite
    sequence s_load_taken;
        p.ld;
    endsequence

    property p_load_fields;
        @(posedge clk) disable iff (!reset_n)
        s_load_taken |=> (bp_q == $past(p.ld_val.bp)) && (rx_q == $past(p.ld_val.pause))
            && (tx_q == $past(p.ld_val.pause));
    endproperty

    a_load_fields: assert property (p_load_fields)
        else $error("loaded strap values not taken into fields");

    // sampled reset_n keeps the release edge out: the flops still reset on that edge
    a_rx_select: assert property (
        @(posedge clk) disable iff (!reset_n)
        reset_n && !p.link.half_duplex && !manual_path
            |=> p.rx_en == $past(p.link.an_rx_pause))
        else $error("receive pause does not follow negotiation");

    a_tx_manual: assert property (
        @(posedge clk) disable iff (!reset_n)
        !p.link.half_duplex && man_eff && !p.ld && !p.wr ##1 !p.ld && !p.wr
            |-> p.tx_en == tx_q)
        else $error("transmit pause does not follow manual field");

    a_half_no_pause: assert property (
        @(posedge clk) disable iff (!reset_n)
        reset_n && p.link.half_duplex |=> !p.rx_en && !p.tx_en && p.rdata[`PFC_BIT_DUP])
        else $error("pause reported active in half duplex");

    a_mac_forced: assert property (
        @(posedge clk) disable iff (!reset_n)
        man_force |-> p.rdata[`PFC_BIT_MAN] ##1 man_q == $past(man_q))
        else $error("manual select not forced in mac mode");
endmodule : pfc_port

// ### pfc_regs.sv
// port 2 and port 0 flow-control configuration register bank
`include "pfc_cfg.svh"

// Contract
// - bit 6 enables half-duplex backpressure
// - bit 5 reads duplex, 1 is half
// - bit 4 reads receive pause in force
// - bit 3 reads transmit pause in force
// - bit 2 gates pause detection when manual
// - bit 1 gates pause generation when manual
// - negotiation decides unless manual or disabled
// - manual select: fields alone decide full duplex
// - port 0 follows same manual condition
// - writes never touch advertisement registers
// - defaults come from straps at reset
// - loader rewrite refreshes strap-derived fields
// - 32-bit registers, bits 31:7 reserved
// - port 0 mac mode forces manual
// - port 0 bit 1 gates generation
module pfc_regs (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PFC_ADDR_W-1:0] reg_addr,
    input wire logic [`PFC_DATA_W-1:0] reg_wdata,
    output logic [`PFC_DATA_W-1:0] reg_rdata,
    output logic reg_ack,
    input wire logic p2_backpressure_default_pin,
    input wire logic p2_pause_default_pin,
    input wire logic p2_manual_select_default_pin,
    input wire logic p0_backpressure_default_pin,
    input wire logic p0_pause_default_pin,
    input wire logic p0_manual_select_default_pin,
    input wire logic p0_mac_mode_pin,
    input wire logic eeprom_load_valid,
    input wire logic [2:0] eeprom_p2_strap,
    input wire logic [2:0] eeprom_p0_strap,
    input wire logic p2_an_enable,
    input wire logic p2_half_duplex,
    input wire logic p2_an_rx_pause,
    input wire logic p2_an_tx_pause,
    input wire logic p0_an_enable,
    input wire logic p0_half_duplex,
    input wire logic p0_an_rx_pause,
    input wire logic p0_an_tx_pause,
    output logic p2_backpressure_enable,
    output logic p2_rx_pause_active,
    output logic p2_tx_pause_active,
    output logic p0_backpressure_enable,
    output logic p0_rx_pause_active,
    output logic p0_tx_pause_active,
    output logic p0_mac_mode
);
    logic [`PFC_STRAP_W-1:0] strap_meta_q;
    logic [`PFC_STRAP_W-1:0] strap_sync_q;
    logic [1:0] settle_cnt_q;
    logic captured_q;
    logic mac_mode_q;
    logic strap_ld;
    logic hit_p2;
    logic hit_p0;
    logic [`PFC_DATA_W-1:0] rdata_d;
    logic [`PFC_DATA_W-1:0] rdata_q;
    logic ack_q;

    pfc_port_if p2_if();
    pfc_port_if p0_if();

    // strap pins are asynchronous to clk; the first stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else begin
            strap_meta_q <= {p0_mac_mode_pin, p0_manual_select_default_pin,
                             p0_pause_default_pin, p0_backpressure_default_pin,
                             p2_manual_select_default_pin, p2_pause_default_pin,
                             p2_backpressure_default_pin};
            strap_sync_q <= strap_meta_q;
        end
    end

    // wait for the synchroniser to fill before trusting the straps, then latch once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_cnt_q <= `PFC_CNT_RST;
            captured_q <= 1'b0;
        end else if (!captured_q) begin
            if (settle_cnt_q == `PFC_STRAP_SETTLE) begin
                captured_q <= 1'b1;
            end else begin
                settle_cnt_q <= settle_cnt_q + `PFC_CNT_ONE;
            end
        end
    end

    assign strap_ld = ~captured_q && (settle_cnt_q == `PFC_STRAP_SETTLE);

    // mac mode is a strap too; held from capture on, loader cannot change it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mac_mode_q <= 1'b0;
        end else if (strap_ld) begin
            mac_mode_q <= strap_sync_q[6];
        end
    end

    // address decode; only the two documented words exist
    assign hit_p2 = (reg_addr == `PFC_P2_OFFSET);
    assign hit_p0 = (reg_addr == `PFC_P0_OFFSET);

    // port 2 slice wiring
    assign p2_if.wr = reg_wr & hit_p2;
    assign p2_if.wdata = reg_wdata[`PFC_FIELD_W-1:0];
    assign p2_if.ld = strap_ld | eeprom_load_valid;
    assign p2_if.ld_val = strap_ld ? pfc_pkg::pfc_strap_s'({strap_sync_q[0], strap_sync_q[1],
                                                            strap_sync_q[2]})
                                   : pfc_pkg::pfc_strap_s'(eeprom_p2_strap);
    assign p2_if.mac_mode = 1'b0;
    assign p2_if.link = {p2_an_enable, p2_half_duplex, p2_an_rx_pause, p2_an_tx_pause};

    // port 0 slice wiring; its negotiation input is the emulated phy's enable
    assign p0_if.wr = reg_wr & hit_p0;
    assign p0_if.wdata = reg_wdata[`PFC_FIELD_W-1:0];
    assign p0_if.ld = strap_ld | eeprom_load_valid;
    assign p0_if.ld_val = strap_ld ? pfc_pkg::pfc_strap_s'({strap_sync_q[3], strap_sync_q[4],
                                                            strap_sync_q[5]})
                                   : pfc_pkg::pfc_strap_s'(eeprom_p0_strap);
    assign p0_if.mac_mode = mac_mode_q;
    assign p0_if.link = {p0_an_enable, p0_half_duplex, p0_an_rx_pause, p0_an_tx_pause};

    pfc_port #(
        .HAS_MAC_MODE(1'b0)
    ) u_port2 (
        .clk(clk),
        .reset_n(reset_n),
        .p(p2_if.port)
    );

    pfc_port #(
        .HAS_MAC_MODE(1'b1)
    ) u_port0 (
        .clk(clk),
        .reset_n(reset_n),
        .p(p0_if.port)
    );

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (hit_p2) begin
            rdata_d = {{`PFC_RSVD_W{1'b0}}, p2_if.rdata};
        end else if (hit_p0) begin
            rdata_d = {{`PFC_RSVD_W{1'b0}}, p0_if.rdata};
        end
    end

    // every access is answered one cycle later, mapped or not
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= reg_rd | reg_wr;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;

    // enables toward the macs, all from slice flops; p0_mac_mode comes from the top's mac_mode_q
    assign p2_backpressure_enable = p2_if.bp_en;
    assign p2_rx_pause_active = p2_if.rx_en;
    assign p2_tx_pause_active = p2_if.tx_en;
    assign p0_backpressure_enable = p0_if.bp_en;
    assign p0_rx_pause_active = p0_if.rx_en;
    assign p0_tx_pause_active = p0_if.tx_en;
    assign p0_mac_mode = mac_mode_q;

    // counter at one: the release edge itself is a reset edge, so start one later
    sequence s_release;
        !captured_q && settle_cnt_q == `PFC_CNT_ONE;
    endsequence

    a_strap_capture: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_release |-> ##1 strap_ld ##1 captured_q)
        else $error("straps not captured two cycles after release");

    a_read_answer: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_rd |=> reg_ack && reg_rdata[`PFC_DATA_W-1:`PFC_FIELD_W] == '0)
        else $error("read not answered or reserved bits set");

    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_rd && !hit_p2 && !hit_p0 |=> reg_rdata == '0)
        else $error("unmapped address read nonzero");

    a_p2_write_bp: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_wr && hit_p2 && !p2_if.ld
            |=> p2_backpressure_enable == $past(reg_wdata[`PFC_BIT_BP]))
        else $error("port 2 backpressure write not applied");

    a_p0_write_tx: assert property (
        @(posedge clk) disable iff (!reset_n)
        reg_wr && hit_p0 && !p0_if.ld ##1 !p0_if.ld && !p0_if.wr && p0_if.mac_mode
            && !p0_half_duplex |=> p0_tx_pause_active == $past(reg_wdata[`PFC_BIT_TX], 2))
        else $error("port 0 transmit pause gate not applied");
endmodule : pfc_regs

// ### pfc_regs_tb_top.sv
// self-checking bench for the port 2 / port 0 flow-control register bank
`include "pfc_cfg.svh"

module pfc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, reset_n, reg_wr, reg_rd, mac_pin, ld, mac_o, mac;
    logic [`PFC_ADDR_W-1:0] reg_addr, a;
    logic [`PFC_DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic reg_ack;
    logic [2:0] s2, s0, e2, e0; // straps are {bp, pause, manual}
    wire [2:0] o2, o0; // one port output per bit, so nets
    logic [3:0] l2, l0; // link is {an_enable, half, an_rx, an_tx}
    logic [6:0] f2, f0; // shadow of the writable fields
    int n_fail, samples_checked, cyc, k;

    pfc_regs pfc_regs_i (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .p2_backpressure_default_pin(s2[2]), .p2_pause_default_pin(s2[1]),
        .p2_manual_select_default_pin(s2[0]), .p0_backpressure_default_pin(s0[2]),
        .p0_pause_default_pin(s0[1]), .p0_manual_select_default_pin(s0[0]),
        .p0_mac_mode_pin(mac_pin), .eeprom_load_valid(ld), .eeprom_p2_strap(e2),
        .eeprom_p0_strap(e0), .p2_an_enable(l2[3]), .p2_half_duplex(l2[2]),
        .p2_an_rx_pause(l2[1]), .p2_an_tx_pause(l2[0]), .p0_an_enable(l0[3]),
        .p0_half_duplex(l0[2]), .p0_an_rx_pause(l0[1]), .p0_an_tx_pause(l0[0]),
        .p2_backpressure_enable(o2[2]), .p2_rx_pause_active(o2[1]),
        .p2_tx_pause_active(o2[0]), .p0_backpressure_enable(o0[2]),
        .p0_rx_pause_active(o0[1]), .p0_tx_pause_active(o0[0]), .p0_mac_mode(mac_o));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // expected register word: half duplex kills pause, manual or no negotiation uses fields
    function automatic logic [31:0] expv(logic [6:0] f, logic [3:0] l, logic m);
        logic man, use_f;
        man = f[0] | m;
        use_f = man | ~l[3];
        expv = 32'h0;
        expv[6] = f[6];
        expv[5] = l[2];
        expv[4] = ~l[2] & (use_f ? f[2] : l[1]);
        expv[3] = ~l[2] & (use_f ? f[1] : l[0]);
        expv[2:0] = {f[2], f[1], man};
    endfunction : expv

    // pause strap feeds both rx and tx enables
    function automatic logic [6:0] from_strap(logic [2:0] s);
        from_strap = {s[2], 3'h0, s[1], s[1], s[0]};
    endfunction : from_strap

    task automatic chk(logic [31:0] got, logic [31:0] want, string what);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : chk

    // one single-cycle access; ack is due just after the taking edge
    task automatic bus(bit wr, logic [8:0] ad, logic [31:0] wd);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 chk({31'h0, reg_ack}, 32'h1, "ack");
    endtask : bus

    task automatic rd_chk(logic [8:0] ad, logic [31:0] want);
        bus(1'b0, ad, 32'h0);
        chk(reg_rdata, want, "read");
    endtask : rd_chk

    task automatic check_all;
        logic [31:0] w2, w0;
        w2 = expv(f2, l2, 1'b0);
        w0 = expv(f0, l0, mac);
        rd_chk(`PFC_P2_OFFSET, w2);
        rd_chk(`PFC_P0_OFFSET, w0);
        chk({25'h0, o2, o0, mac_o}, {25'h0, w2[6], w2[4:3], w0[6], w0[4:3], mac}, "pins");
    endtask : check_all

    // strap defaults are random; wait past the synchroniser and strap load
    task automatic do_reset(logic m);
        @(posedge clk);
        reset_n <= 1'b0;
        s2 <= 3'($urandom);
        s0 <= 3'($urandom);
        mac_pin <= m;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        f2 = from_strap(s2);
        f0 = from_strap(s0);
        mac = m;
        check_all();
        $display("test reset mac=%0d done", m);
    endtask : do_reset

    task automatic run_traffic;
        repeat (40) begin
            k = $urandom_range(2);
            a = (k == 0) ? `PFC_P2_OFFSET : (k == 1) ? `PFC_P0_OFFSET : 9'h1ac + 9'($urandom_range(80));
            d = $urandom;
            // link levels move on a rising edge like every other input
            @(posedge clk);
            l2 <= 4'($urandom);
            l0 <= 4'($urandom);
            bus(1'b1, a, d);
            if (k == 0) f2 = {d[6], 3'h0, d[2:0]};
            if (k == 1) f0 = {d[6], 3'h0, d[2:0]};
            if (k == 2) rd_chk(a, 32'h0);
            check_all();
        end
        // reserved bits set, manual cleared: reserved ignored, forced manual holds
        bus(1'b1, `PFC_P0_OFFSET, 32'hffffff80);
        f0 = 7'h0;
        check_all();
        repeat (8) begin
            @(posedge clk);
            ld <= 1'b1;
            e2 <= 3'($urandom);
            e0 <= 3'($urandom);
            @(posedge clk);
            ld <= 1'b0;
            f2 = from_strap(e2);
            f0 = from_strap(e0);
            check_all();
        end
        // write colliding with a loader rewrite: the loader wins
        @(posedge clk);
        ld <= 1'b1;
        e2 <= 3'h2;
        reg_wr <= 1'b1;
        reg_addr <= `PFC_P2_OFFSET;
        reg_wdata <= 32'h45;
        @(posedge clk);
        ld <= 1'b0;
        reg_wr <= 1'b0;
        f2 = from_strap(3'h2);
        f0 = from_strap(e0);
        check_all();
        $display("test traffic mac=%0d done", mac);
    endtask : run_traffic

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // hang guard, well above the fewer than a thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // main sequence: reset, traffic, then a mid-run reset into mac mode
    initial begin
        void'($urandom(32'h70a34357));
        {reset_n, reg_wr, reg_rd, mac_pin, ld} = 5'h0;
        reg_addr = 9'h0;
        reg_wdata = 32'h0;
        {s2, s0, e2, e0} = 12'h0;
        l2 = 4'($urandom);
        l0 = 4'($urandom);
        do_reset(1'b0);
        run_traffic();
        do_reset(1'b1);
        run_traffic();
        final_report();
    end
endmodule : pfc_regs_tb_top
